// ### pkg/pud_pkg.sv
package pud_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PIXEL_FORMAT    = 8'h0A;
	localparam logic [7:0] IDX_SIXTEEN_CTRL    = 8'h0C;
	localparam logic [7:0] IDX_MISC_ONE        = 8'h70;
	localparam logic [7:0] IDX_MISC_THREE      = 8'h72;
	localparam logic [7:0] IDX_KEY_DBUF_CTRL   = 8'h78;
	localparam logic [7:0] IDX_PACKED_CTRL     = 8'h0D;
	localparam logic [7:0] IDX_THIRTY_TWO_CTRL = 8'h0E;
	localparam logic [7:0] IDX_PIXEL_MASK      = 8'h03;
	localparam logic [7:0] IDX_PALETTE_CTRL    = 8'h1C;
	localparam logic [7:0] IDX_KEY_VALUE       = 8'h7A;
	localparam logic [7:0] IDX_KEY_MASK        = 8'h7B;
	localparam logic [7:0] IDX_STATUS          = 8'h7F;
	localparam int         ADR_WIDTH           = 10;
	localparam int         ADR_LSB             = 2;

	// Field positions
	localparam int BIT_DBUF_ENABLE      = 0;
	localparam int BIT_KEY_OR_SUPPRESS  = 0;
	localparam int BIT_FMT_565          = 1;
	localparam int BIT_LOW_FILL         = 2;
	localparam int BIT_CONTIG_ADDR      = 5;
	localparam int BIT_PATH16_LO        = 6;
	localparam int BIT_MEM_WIDTH_64     = 0;
	localparam int BIT_PACKED_PATH      = 0;
	localparam int BIT_PATH32_LO        = 0;
	localparam int BIT_BYPASS_POL32     = 2;
	localparam int BIT_OVERLAY_PATH     = 3;
	localparam int PARTITION_LO         = 0;

	// Reset values of every writable register
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam logic [7:0] MASK_RESET   = 8'hFF;

	// Pixel format codes and colour-path codes
	localparam logic [2:0] FMT_SIXTEEN  = 3'h4;
	localparam logic [2:0] FMT_PACKED   = 3'h5;
	localparam logic [2:0] FMT_THIRTY2  = 3'h6;
	localparam logic [1:0] PATH_INDIRECT = 2'h0;
	localparam logic [1:0] PATH_DYNAMIC  = 2'h1;
	localparam logic [1:0] PATH_DIRECT   = 2'h3;

	// Packed group: accesses and pixels per group; default port width
	localparam int PACKED_ACCESSES   = 3;
	localparam int PACKED_PIXELS     = 8;
	localparam int PORT_WIDTH_DEF    = 64;

	// Active pixel unpacking mode
	typedef enum logic [1:0] {
		MODE_IDLE   = 2'b00,
		MODE_DBUF   = 2'b01,
		MODE_PACKED = 2'b10,
		MODE_WIDE   = 2'b11
	} pud_mode_e;

	// One unpacked pixel toward the palette or converters
	typedef struct packed {
		logic       direct;
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} pud_pixel_s;

	// Effective controls derived from the register bank
	typedef struct packed {
		logic       suppress;
		logic       keyOn;
		logic [1:0] path16;
		logic       lowFill;
		logic       contig;
		logic [2:0] partition;
		logic       packedPath;
		logic [1:0] path32;
		logic       bypassPol;
		logic       overlayPath;
		logic [7:0] pixMask;
		logic [7:0] keyValue;
		logic [7:0] keyMask;
	} pud_ctrl_s;

endpackage

// ### rtl/pud_pixel_unpack.sv
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module pud_pixel_unpack #(
	parameter int PORT_WIDTH = pud_pkg::PORT_WIDTH_DEF
) (
	input  wire logic                           clock,
	input  wire logic                           arst_n,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [pud_pkg::ADR_WIDTH-1:0]  wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [31:0]                    wb_dat_i,
	output logic      [31:0]                    wb_dat_o,
	output logic                                wb_ack_o,
	input  wire logic [PORT_WIDTH-1:0]          memoryInputBits,
	input  wire logic                           shiftClockIn,
	input  wire logic                           lineStart,
	output pud_pkg::pud_pixel_s                 pixelOut,
	output logic                                pixelValid,
	output logic      [2:0]                     shiftClockFormat
);

	// Only the full 64-bit port is built
	if (PORT_WIDTH != 64) begin : g_bad_width
		$error("pud_pixel_unpack: PORT_WIDTH must be 64");
	end

	localparam int BUF_BITS = PORT_WIDTH * pud_pkg::PACKED_ACCESSES;

	// Register bank
	logic [7:0] pixelFormatSelect_ff;       // Format code in low bits
	logic [7:0] sixteenBitPixelControl_ff;  // Fill, addressing, path
	logic [7:0] miscControlOne_ff;          // Memory width select
	logic [7:0] miscControlThree_ff;        // Double-buffer enable
	logic [7:0] keyAndDoubleBufferCtrl_ff;  // Key enable or suppress
	logic [7:0] packedControl_ff;           // Packed path
	logic [7:0] thirtyTwoControl_ff;        // 32 BPP paths and polarity
	logic [7:0] pixelMask_ff;               // Pixel mask
	logic [7:0] paletteControl_ff;          // Partition
	logic [7:0] keyValue_ff;                // Key value
	logic [7:0] keyMask_ff;                 // Key mask

	// Bus decode
	logic                               busReq;       // New request, no ack yet
	logic [pud_pkg::ADR_WIDTH-3:0]      regIndex;     // Word index
	logic                               wrLow;        // Write on byte lane 0
	logic [7:0]                         nxt_readData; // Read mux result
	logic                               lastSelect_ff; // Last buffer chosen

	assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign regIndex = wb_adr_i[pud_pkg::ADR_WIDTH-1:pud_pkg::ADR_LSB];
	assign wrLow    = busReq && wb_we_i && wb_sel_i[0];

	// Synchronised link signals
	logic [PORT_WIDTH-1:0] dataMeta_ff;   // First stage, read only by next
	logic [PORT_WIDTH-1:0] dataSync_ff;   // Stable pixel word
	logic [1:0]            sclkMeta_ff;   // First stage of clock and line
	logic [1:0]            sclkSync_ff;   // Second stage
	logic [1:0]            sclkPrev_ff;   // For edge detection
	logic                  sclkRise;      // Access strobe
	logic                  lineRise;      // Line begins

	// Mode and effective controls
	pud_pkg::pud_mode_e mode;
	pud_pkg::pud_ctrl_s ctl;
	logic               dbActive;
	logic               wide64;

	// Unpack pipeline
	logic [BUF_BITS-1:0] packBuf_ff;     // Packed accumulation
	logic [BUF_BITS-1:0] workBuf_ff;     // Word(s) being emitted
	logic [1:0]          packPhase_ff;   // Access within packed triple
	logic [3:0]          emitLeft_ff;    // Pixels still to send
	logic [2:0]          emitIdx_ff;     // Next pixel position
	pud_pkg::pud_mode_e  workMode_ff;    // Mode latched with the data

	// Register writes, one byte lane
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pixelFormatSelect_ff      <= pud_pkg::REG_RESET;
			sixteenBitPixelControl_ff <= pud_pkg::REG_RESET;
			miscControlOne_ff         <= pud_pkg::REG_RESET;
			miscControlThree_ff       <= pud_pkg::REG_RESET;
			keyAndDoubleBufferCtrl_ff <= pud_pkg::REG_RESET;
			packedControl_ff          <= pud_pkg::REG_RESET;
			thirtyTwoControl_ff       <= pud_pkg::REG_RESET;
			pixelMask_ff              <= pud_pkg::MASK_RESET;
			paletteControl_ff         <= pud_pkg::REG_RESET;
			keyValue_ff               <= pud_pkg::REG_RESET;
			keyMask_ff                <= pud_pkg::MASK_RESET;
		end else if (wrLow) begin
			// Unmapped and status writes are dropped
			case (regIndex)
				pud_pkg::IDX_PIXEL_FORMAT:    pixelFormatSelect_ff      <= wb_dat_i[7:0];
				pud_pkg::IDX_SIXTEEN_CTRL:    sixteenBitPixelControl_ff <= wb_dat_i[7:0];
				pud_pkg::IDX_MISC_ONE:        miscControlOne_ff         <= wb_dat_i[7:0];
				pud_pkg::IDX_MISC_THREE:      miscControlThree_ff       <= wb_dat_i[7:0];
				pud_pkg::IDX_KEY_DBUF_CTRL:   keyAndDoubleBufferCtrl_ff <= wb_dat_i[7:0];
				pud_pkg::IDX_PACKED_CTRL:     packedControl_ff          <= wb_dat_i[7:0];
				pud_pkg::IDX_THIRTY_TWO_CTRL: thirtyTwoControl_ff       <= wb_dat_i[7:0];
				pud_pkg::IDX_PIXEL_MASK:      pixelMask_ff              <= wb_dat_i[7:0];
				pud_pkg::IDX_PALETTE_CTRL:    paletteControl_ff         <= wb_dat_i[7:0];
				pud_pkg::IDX_KEY_VALUE:       keyValue_ff               <= wb_dat_i[7:0];
				pud_pkg::IDX_KEY_MASK:        keyMask_ff                <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (regIndex)
			pud_pkg::IDX_PIXEL_FORMAT:    nxt_readData = pixelFormatSelect_ff;
			pud_pkg::IDX_SIXTEEN_CTRL:    nxt_readData = sixteenBitPixelControl_ff;
			pud_pkg::IDX_MISC_ONE:        nxt_readData = miscControlOne_ff;
			pud_pkg::IDX_MISC_THREE:      nxt_readData = miscControlThree_ff;
			pud_pkg::IDX_KEY_DBUF_CTRL:   nxt_readData = keyAndDoubleBufferCtrl_ff;
			pud_pkg::IDX_PACKED_CTRL:     nxt_readData = packedControl_ff;
			pud_pkg::IDX_THIRTY_TWO_CTRL: nxt_readData = thirtyTwoControl_ff;
			pud_pkg::IDX_PIXEL_MASK:      nxt_readData = pixelMask_ff;
			pud_pkg::IDX_PALETTE_CTRL:    nxt_readData = paletteControl_ff;
			pud_pkg::IDX_KEY_VALUE:       nxt_readData = keyValue_ff;
			pud_pkg::IDX_KEY_MASK:        nxt_readData = keyMask_ff;
			// Live state: mode, phase, key enable and last buffer
			pud_pkg::IDX_STATUS:
				nxt_readData = {2'h0, mode, packPhase_ff, ctl.keyOn, lastSelect_ff};
			default:                      nxt_readData = 8'h00;
		endcase
	end

	// Wishbone answer one cycle after the request, dropped next cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? {24'h00_0000, nxt_readData} : 32'h0000_0000;
		end
	end

	// Bit 0 of key control has two meanings by mode
	assign dbActive = miscControlThree_ff[pud_pkg::BIT_DBUF_ENABLE]
		&& (pixelFormatSelect_ff[2:0] == pud_pkg::FMT_SIXTEEN);
	assign wide64   = miscControlOne_ff[pud_pkg::BIT_MEM_WIDTH_64];

	// Derived controls
	always_comb begin
		ctl.suppress    = dbActive && keyAndDoubleBufferCtrl_ff[pud_pkg::BIT_KEY_OR_SUPPRESS];
		ctl.keyOn       = !dbActive && keyAndDoubleBufferCtrl_ff[pud_pkg::BIT_KEY_OR_SUPPRESS];
		ctl.path16      = sixteenBitPixelControl_ff[pud_pkg::BIT_PATH16_LO +: 2];
		ctl.lowFill     = sixteenBitPixelControl_ff[pud_pkg::BIT_LOW_FILL];
		ctl.contig      = sixteenBitPixelControl_ff[pud_pkg::BIT_CONTIG_ADDR];
		ctl.partition   = paletteControl_ff[pud_pkg::PARTITION_LO +: 3];
		ctl.packedPath  = packedControl_ff[pud_pkg::BIT_PACKED_PATH];
		ctl.path32      = thirtyTwoControl_ff[pud_pkg::BIT_PATH32_LO +: 2];
		ctl.bypassPol   = thirtyTwoControl_ff[pud_pkg::BIT_BYPASS_POL32];
		ctl.overlayPath = thirtyTwoControl_ff[pud_pkg::BIT_OVERLAY_PATH];
		ctl.pixMask     = pixelMask_ff;
		ctl.keyValue    = keyValue_ff;
		ctl.keyMask     = keyMask_ff;
	end

	// Mode from format code; other formats are handled elsewhere
	always_comb begin
		if (dbActive) begin
			mode = pud_pkg::MODE_DBUF;
		end else if (pixelFormatSelect_ff[2:0] == pud_pkg::FMT_PACKED) begin
			mode = pud_pkg::MODE_PACKED;
		end else if (pixelFormatSelect_ff[2:0] == pud_pkg::FMT_THIRTY2) begin
			mode = pud_pkg::MODE_WIDE;
		end else begin
			mode = pud_pkg::MODE_IDLE;
		end
	end

	// Two-stage synchronisers for pixel word, shift clock and line start
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dataMeta_ff <= '0;
			dataSync_ff <= '0;
			sclkMeta_ff <= 2'h0;
			sclkSync_ff <= 2'h0;
			sclkPrev_ff <= 2'h0;
		end else begin
			dataMeta_ff <= memoryInputBits;
			dataSync_ff <= dataMeta_ff;
			sclkMeta_ff <= {lineStart, shiftClockIn};
			sclkSync_ff <= sclkMeta_ff;
			sclkPrev_ff <= sclkSync_ff;
		end
	end

	assign sclkRise = sclkSync_ff[0] && !sclkPrev_ff[0];
	assign lineRise = sclkSync_ff[1] && !sclkPrev_ff[1];

	// 555 to 24 bits: split, then route indirect or direct
	function automatic pud_pkg::pud_pixel_s conv555(input logic [14:0] p,
		input pud_pkg::pud_ctrl_s c);
		pud_pkg::pud_pixel_s o;
		logic [4:0] r;
		logic [4:0] g;
		logic [4:0] b;
		r = p[14:10];
		g = p[9:5];
		b = p[4:0];
		o.direct = (c.path16 == pud_pkg::PATH_DIRECT);
		if (o.direct) begin
			// Linear fill copies the top bits; zero fill cannot reach full scale
			o.red   = {r, c.lowFill ? r[4:2] : 3'h0};
			o.green = {g, c.lowFill ? g[4:2] : 3'h0};
			o.blue  = {b, c.lowFill ? b[4:2] : 3'h0};
		end else if (c.contig) begin
			o.red   = {c.partition, r};
			o.green = {c.partition, g};
			o.blue  = {c.partition, b};
		end else begin
			// Sparse: pixel bits are the high address bits
			o.red   = {r, 3'h0};
			o.green = {g, 3'h0};
			o.blue  = {b, 3'h0};
		end
		return o;
	endfunction

	// Three colour bytes through one path
	function automatic pud_pkg::pud_pixel_s route24(input logic [23:0] p,
		input logic direct, input logic maskBoth, input logic [7:0] m);
		pud_pkg::pud_pixel_s o;
		logic [7:0] k;
		k = (direct && !maskBoth) ? 8'hFF : m;
		o.direct = direct;
		o.blue   = p[7:0] & k;
		o.green  = p[15:8] & k;
		o.red    = p[23:16] & k;
		return o;
	endfunction

	// One 32-bit group in 32 BPP
	function automatic pud_pkg::pud_pixel_s conv32(input logic [31:0] p,
		input pud_pkg::pud_ctrl_s c);
		pud_pkg::pud_pixel_s o;
		logic [7:0] ovl;
		logic       match;
		logic       dyn;
		ovl   = p[31:24];
		match = (ovl & c.keyMask) == (c.keyValue & c.keyMask);
		dyn   = !c.keyOn && (c.path32 == pud_pkg::PATH_DYNAMIC);
		if (c.keyOn && !match) begin
			// Overlay byte drives all three channels
			o.direct = c.overlayPath;
			o.red    = c.overlayPath ? ovl : (ovl & c.pixMask);
			o.green  = o.red;
			o.blue   = o.red;
		end else if (dyn) begin
			// Bits above bit 24 are ignored
			o = route24(p[23:0], p[24] ^ c.bypassPol, 1'b1, c.pixMask);
		end else begin
			o = route24(p[23:0], c.path32 == pud_pkg::PATH_DIRECT, 1'b0, c.pixMask);
		end
		return o;
	endfunction

	// Capture accesses and hand them to the emitter
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			packBuf_ff   <= '0;
			workBuf_ff   <= '0;
			packPhase_ff <= 2'h0;
			emitLeft_ff  <= 4'h0;
			emitIdx_ff   <= 3'h0;
			workMode_ff  <= pud_pkg::MODE_IDLE;
		end else if (lineRise) begin
			packPhase_ff <= 2'h0;
			emitLeft_ff  <= 4'h0;
		end else if (sclkRise && mode == pud_pkg::MODE_PACKED) begin
			// Pixels may straddle accesses, so wait for all three
			packBuf_ff[PORT_WIDTH*packPhase_ff +: PORT_WIDTH] <= dataSync_ff;
			if (packPhase_ff == 2'(pud_pkg::PACKED_ACCESSES - 1)) begin
				packPhase_ff <= 2'h0;
				workBuf_ff   <= {dataSync_ff, packBuf_ff[2*PORT_WIDTH-1:0]};
				emitLeft_ff  <= 4'(pud_pkg::PACKED_PIXELS);
				emitIdx_ff   <= 3'h0;
				workMode_ff  <= pud_pkg::MODE_PACKED;
			end else begin
				packPhase_ff <= packPhase_ff + 2'h1;
				emitLeft_ff  <= 4'h0;
			end
		end else if (sclkRise && mode != pud_pkg::MODE_IDLE) begin
			// One pixel per 32-bit group, two on a 64-bit port
			workBuf_ff  <= {{(BUF_BITS-PORT_WIDTH){1'b0}}, dataSync_ff};
			emitLeft_ff <= wide64 ? 4'h2 : 4'h1;
			emitIdx_ff  <= 3'h0;
			workMode_ff <= mode;
		end else if (emitLeft_ff != 4'h0) begin
			emitLeft_ff <= emitLeft_ff - 4'h1;
			emitIdx_ff  <= emitIdx_ff + 3'h1;
		end
	end

	// Emit one pixel per clock from the work buffer
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pixelOut      <= '0;
			pixelValid    <= 1'b0;
			lastSelect_ff <= 1'b0;
		end else if (emitLeft_ff != 4'h0 && !lineRise && !sclkRise) begin
			pixelValid <= 1'b1;
			unique case (workMode_ff)
				pud_pkg::MODE_DBUF: begin
					// Select bit 0 is A, 1 is B; suppress forces A
					if (ctl.suppress || !workBuf_ff[32*emitIdx_ff + 31]) begin
						pixelOut      <= conv555(workBuf_ff[32*emitIdx_ff +: 15], ctl);
						lastSelect_ff <= 1'b0;
					end else begin
						pixelOut      <= conv555(workBuf_ff[32*emitIdx_ff + 16 +: 15], ctl);
						lastSelect_ff <= 1'b1;
					end
				end
				pud_pkg::MODE_PACKED:
					pixelOut <= route24(workBuf_ff[24*emitIdx_ff +: 24],
						ctl.packedPath, 1'b0, ctl.pixMask);
				pud_pkg::MODE_WIDE:
					pixelOut <= conv32(workBuf_ff[32*emitIdx_ff +: 32], ctl);
				pud_pkg::MODE_IDLE:
					pixelValid <= 1'b0;
			endcase
		end else begin
			pixelValid <= 1'b0;
		end
	end

	// Shift clock generator timing: double buffer uses the 32 BPP figures
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shiftClockFormat <= 3'h0;
		end else begin
			shiftClockFormat <= dbActive ? pud_pkg::FMT_THIRTY2 : pixelFormatSelect_ff[2:0];
		end
	end

endmodule // pud_pixel_unpack

// ### testbench/pud_pixel_unpack_asserts.sv
`timescale 1ns/1ps
// Watches bus and pixel ports; mirrors only the mode bits it needs
module pud_pixel_unpack_chk (
	input wire logic                          clock,
	input wire logic                          arst_n,
	input wire logic                          wb_cyc_i,
	input wire logic                          wb_stb_i,
	input wire logic                          wb_we_i,
	input wire logic [pud_pkg::ADR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0]                    wb_sel_i,
	input wire logic [31:0]                   wb_dat_i,
	input wire logic [31:0]                   wb_dat_o,
	input wire logic                          wb_ack_o,
	input wire pud_pkg::pud_pixel_s           pixelOut,
	input wire logic                          pixelValid,
	input wire logic [2:0]                    shiftClockFormat
);
	logic [2:0] fmt_ff;    // Pixel format code
	logic       w64_ff;    // 64-bit port width
	logic       dbuf_ff;   // Double-buffer enable
	logic [1:0] path16_ff; // 16-bit colour path
	logic       pack_ff;   // Packed colour path
	logic       wrHit;     // Write acked this edge, stored the edge before
	logic       dbufOn;    // Double-buffer mode active
	logic [7:0] idx;       // Register index
	assign idx = wb_adr_i[9:2];
	assign wrHit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign dbufOn = dbuf_ff && (fmt_ff == pud_pkg::FMT_SIXTEEN);
	// Mirror on the ack edge, one cycle after the edge the bank stores at
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fmt_ff    <= 3'h0;
			w64_ff    <= 1'b0;
			dbuf_ff   <= 1'b0;
			path16_ff <= 2'h0;
			pack_ff   <= 1'b0;
		end else if (wrHit) begin
			if (idx == pud_pkg::IDX_PIXEL_FORMAT) fmt_ff <= wb_dat_i[2:0];
			if (idx == pud_pkg::IDX_MISC_ONE) w64_ff <= wb_dat_i[0];
			if (idx == pud_pkg::IDX_MISC_THREE) dbuf_ff <= wb_dat_i[0];
			if (idx == pud_pkg::IDX_SIXTEEN_CTRL) path16_ff <= wb_dat_i[7:6];
			if (idx == pud_pkg::IDX_PACKED_CTRL) pack_ff <= wb_dat_i[0];
		end
	end
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Two pixels then silence
	sequence sPair;
		pixelValid [*2] ##1 !pixelValid;
	endsequence
	// Eight pixels then silence
	sequence sRun8;
		pixelValid [*8] ##1 !pixelValid;
	endsequence
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request not answered next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Ack held past one cycle");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("Read data not zero outside ack");
	chk_dbuf_pair: assert property ($rose(pixelValid) && dbufOn && w64_ff |-> sPair)
		else $error("Double buffer access not two pixels");
	chk_wide_pair: assert property ($rose(pixelValid) && fmt_ff == pud_pkg::FMT_THIRTY2
		&& w64_ff |-> sPair) else $error("Wide access not two pixels");
	chk_wide_one: assert property ($rose(pixelValid) && fmt_ff == pud_pkg::FMT_THIRTY2
		&& !w64_ff |=> !pixelValid) else $error("Narrow access not one pixel");
	chk_packed_run: assert property ($rose(pixelValid) && fmt_ff == pud_pkg::FMT_PACKED
		|-> sRun8) else $error("Packed group not eight pixels");
	chk_sclk_mode: assert property (pixelValid && dbufOn
		|-> shiftClockFormat == pud_pkg::FMT_THIRTY2) else $error("Shift timing format wrong");
	chk_dbuf_path: assert property (pixelValid && dbufOn
		|-> pixelOut.direct == (path16_ff == pud_pkg::PATH_DIRECT)) else $error("Buffer path wrong");
	chk_pack_path: assert property (pixelValid && fmt_ff == pud_pkg::FMT_PACKED
		|-> pixelOut.direct == pack_ff) else $error("Packed path wrong");
endmodule // pud_pixel_unpack_chk
bind pud_pixel_unpack pud_pixel_unpack_chk pud_pixel_unpack_chk_i (
	.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pixelOut(pixelOut), .pixelValid(pixelValid),
	.shiftClockFormat(shiftClockFormat));

// ### testbench/pud_vram_model.sv
`timescale 1ns/1ps
// Frame-buffer pixel port: one access per 200 ns shift period
module pud_vram_model #(
	parameter int W = 64
) (
	output logic [W-1:0] memoryInputBits,
	output logic         shiftClockIn
);
	// Idle: shift clock stands low, data never a stale word
	initial begin
		shiftClockIn = 1'b0;
		memoryInputBits = '1;
	end
	// Word held well around the edge; odd offset keeps phase unrelated
	task automatic send(input logic [W-1:0] word);
		memoryInputBits = word;
		#63 shiftClockIn = 1'b1;
		#100 shiftClockIn = 1'b0;
		#37 memoryInputBits = ~word;
	endtask
endmodule // pud_vram_model

// ### testbench/tb_pud_pixel_unpack.sv
`timescale 1ns/1ps
// Random bench with corner words for the pixel unpacker
module tb_pud_pixel_unpack;
	logic                clock, arst_n, wbReq, wbWe, wbAck, pixValid, lineStart, sclk;
	logic [9:0]          wbAdr;   // Byte address
	logic [31:0]         wbDatW, wbDatR;
	logic [63:0]         memBits; // Pixel port word
	logic [2:0]          sclkFmt; // Shift timing format
	pud_pkg::pud_pixel_s pix, gotQ[$], expQ[$];
	logic [63:0]         wq[$];   // Accesses of the next frame
	logic [7:0]          mask, kv, km, c16, c32, part, regs[11];
	logic [1:0]          pathTab[4];
	logic                k, pp;   // Key bit, packed path
	int                  n_fail, n_tests;
	pud_pixel_unpack #(.PORT_WIDTH(64)) pud_pixel_unpack_i (
		.clock(clock), .arst_n(arst_n), .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
		.wb_ack_o(wbAck), .memoryInputBits(memBits), .shiftClockIn(sclk), .lineStart(lineStart),
		.pixelOut(pix), .pixelValid(pixValid), .shiftClockFormat(sclkFmt));
	pud_vram_model #(.W(64)) pud_vram_model_i (.memoryInputBits(memBits), .shiftClockIn(sclk));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Hang guard
	initial begin
		#1000000;
		n_fail++;
		end_sim();
	end
	// Collect every emitted pixel
	always @(posedge clock) begin
		if (pixValid === 1'b1) gotQ.push_back(pix);
	end
	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpPix(input pud_pkg::pud_pixel_s got, input pud_pkg::pud_pixel_s exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; held until ack is sampled
	task automatic wbXfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int i;
		wbReq <= 1'b1;
		wbWe <= w;
		wbAdr <= {idx, 2'h0};
		wbDatW <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (wbAck !== 1'b1 && i < 20);
		q = wbDatR[7:0];
		if (i >= 20) end_sim();
		wbReq <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wbXfer(1'b1, idx, d, q);
	endtask
	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		wbXfer(1'b0, idx, 8'h00, q);
		cmp8(q, exp);
	endtask
	// Double buffer cleared before format moves, set only after
	task automatic cfg(input logic [2:0] f, input logic db, input logic wide);
		wr(pud_pkg::IDX_MISC_THREE, 8'h00);
		wr(pud_pkg::IDX_PIXEL_FORMAT, {5'h00, f});
		wr(pud_pkg::IDX_MISC_ONE, {7'h00, wide});
		wr(pud_pkg::IDX_MISC_THREE, {7'h00, db});
		wr(pud_pkg::IDX_KEY_DBUF_CTRL, {7'h00, k});
		wr(pud_pkg::IDX_SIXTEEN_CTRL, c16);
		wr(pud_pkg::IDX_THIRTY_TWO_CTRL, c32);
		wr(pud_pkg::IDX_PACKED_CTRL, {7'h00, pp});
		wr(pud_pkg::IDX_PIXEL_MASK, mask);
		wr(pud_pkg::IDX_PALETTE_CTRL, part);
		wr(pud_pkg::IDX_KEY_VALUE, kv);
		wr(pud_pkg::IDX_KEY_MASK, km);
	endtask
	// Send the queued accesses, then match pixels in order
	task automatic frame();
		foreach (wq[j]) pud_vram_model_i.send(wq[j]);
		wq.delete();
		repeat (16) @(posedge clock);
		cmp8(8'(gotQ.size()), 8'(expQ.size()));
		while (gotQ.size() > 0 && expQ.size() > 0)
			cmpPix(gotQ.pop_front(), expQ.pop_front());
		gotQ.delete();
		expQ.delete();
	endtask
	// Expected pixel; mask applied only when asked
	function automatic pud_pkg::pud_pixel_s px(input logic d, input logic [7:0] r,
		input logic [7:0] g, input logic [7:0] b, input logic m);
		logic [7:0] mm;
		mm = m ? mask : 8'hFF;
		return {d, r & mm, g & mm, b & mm};
	endfunction
	function automatic logic [7:0] fill(input logic [4:0] c);
		return c16[2] ? {c, c[4:2]} : {c, 3'h0};
	endfunction
	function automatic pud_pkg::pud_pixel_s e16(input logic [31:0] g);
		logic [14:0] v;
		v = (g[31] && !k) ? g[30:16] : g[14:0];
		if (c16[7:6] == pud_pkg::PATH_DIRECT) return px(1'b1, fill(v[14:10]), fill(v[9:5]),
			fill(v[4:0]), 1'b0);
		if (c16[5]) return px(1'b0, {part[2:0], v[14:10]}, {part[2:0], v[9:5]},
			{part[2:0], v[4:0]}, 1'b0);
		return px(1'b0, {v[14:10], 3'h0}, {v[9:5], 3'h0}, {v[4:0], 3'h0}, 1'b0);
	endfunction
	function automatic pud_pkg::pud_pixel_s e32(input logic [31:0] w);
		logic d;
		if (k && ((w[31:24] & km) != (kv & km)))
			return px(c32[3], w[31:24], w[31:24], w[31:24], !c32[3]);
		if (c32[1:0] == pud_pkg::PATH_DYNAMIC && !k)
			return px(w[24] ^ c32[2], w[23:16], w[15:8], w[7:0], 1'b1);
		d = c32[1:0] == pud_pkg::PATH_DIRECT;
		return px(d, w[23:16], w[15:8], w[7:0], !d);
	endfunction
	initial begin
		logic [63:0]  w;
		logic [7:0]   q;
		logic [191:0] all;
		{arst_n, wbReq, wbWe, wbAdr, wbDatW, lineStart, n_fail, n_tests} = '0;
		{k, pp, c16, c32, kv, part, km, mask} = {2'h0, 40'h0, 8'hFF, 8'hFF};
		pathTab = '{pud_pkg::PATH_INDIRECT, pud_pkg::PATH_DIRECT, pud_pkg::PATH_DYNAMIC,
			pud_pkg::PATH_DYNAMIC};
		regs = '{pud_pkg::IDX_PIXEL_FORMAT, pud_pkg::IDX_SIXTEEN_CTRL, pud_pkg::IDX_MISC_ONE,
			pud_pkg::IDX_MISC_THREE, pud_pkg::IDX_KEY_DBUF_CTRL, pud_pkg::IDX_PACKED_CTRL,
			pud_pkg::IDX_THIRTY_TWO_CTRL, pud_pkg::IDX_PIXEL_MASK, pud_pkg::IDX_PALETTE_CTRL,
			pud_pkg::IDX_KEY_VALUE, pud_pkg::IDX_KEY_MASK};
		void'($urandom(85662));
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		// Reset values, random write and read back, unmapped place
		foreach (regs[i]) begin
			q = (regs[i] == pud_pkg::IDX_PIXEL_MASK || regs[i] == pud_pkg::IDX_KEY_MASK) ?
				pud_pkg::MASK_RESET : pud_pkg::REG_RESET;
			rdChk(regs[i], q);
			q = 8'($urandom());
			if (regs[i] == pud_pkg::IDX_MISC_THREE) q[0] = 1'b0;
			wr(regs[i], q);
			rdChk(regs[i], q);
		end
		rdChk(8'h40, 8'h00);
		$display("Test registers done");
		// Double buffer: suppress on/off, indirect and direct
		for (int t = 0; t < 4; t++) begin
			k = t[0];
			c16 = {t[1] ? pud_pkg::PATH_DIRECT : pud_pkg::PATH_INDIRECT, 1'($urandom()), 5'h00};
			c16[2] = 1'($urandom()) & (t[1] | c16[5]);
			part = 8'($urandom());
			cfg(pud_pkg::FMT_SIXTEEN, 1'b1, 1'b1);
			for (int j = 0; j < 4; j++) begin
				w = {$urandom(), $urandom()};
				if (j == 0) w = w | 64'h8000_0000_8000_0000;
				wq.push_back(w);
				expQ.push_back(e16(w[31:0]));
				expQ.push_back(e16(w[63:32]));
			end
			frame();
			cmp8({5'h00, sclkFmt}, {5'h00, pud_pkg::FMT_THIRTY2});
			$display("Test double buffer %0d done", t);
		end
		// 32 BPP: indirect, direct and dynamic path codes, polarity, key, narrow port last
		for (int t = 0; t < 9; t++) begin
			k = t[2];
			q[0] = k ? 1'(pathTab[t[1:0]] != pud_pkg::PATH_DIRECT) : t[0];
			c32 = {4'h0, q[0], t[0], pathTab[t[1:0]]};
			{mask, kv, km} = 24'($urandom());
			cfg(pud_pkg::FMT_THIRTY2, 1'b0, 1'(t < 8));
			for (int j = 0; j < 4; j++) begin
				w = {$urandom(), $urandom()};
				if (j[0]) w[31:24] = kv;
				wq.push_back(w);
				expQ.push_back(e32(w[31:0]));
				if (t < 8) expQ.push_back(e32(w[63:32]));
			end
			frame();
			$display("Test 32 BPP %0d done", t);
		end
		// Packed: a lone access gives nothing, line start restarts
		for (int t = 0; t < 2; t++) begin
			pp = t[0];
			mask = 8'($urandom());
			cfg(pud_pkg::FMT_PACKED, 1'b0, 1'b1);
			wq.push_back({$urandom(), $urandom()});
			frame();
			lineStart <= 1'b1;
			repeat (4) @(posedge clock);
			lineStart <= 1'b0;
			repeat (4) @(posedge clock);
			all = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
			for (int j = 0; j < 3; j++) wq.push_back(all[64*j+:64]);
			for (int j = 0; j < 8; j++)
				expQ.push_back(px(pp, all[24*j+16+:8], all[24*j+8+:8], all[24*j+:8], !pp));
			frame();
			$display("Test packed %0d done", t);
		end
		end_sim();
	end
endmodule // tb_pud_pixel_unpack
